// >>> core/aircon_sequencer.sv
// Mode selection and compressor/fan sequencing of a room air conditioner
//
// Contract
// R1: A remote mode command selects heating, cooling, soft dry or automatic.
// R2: Target temperature is accepted only from 16 to 30 degrees.
// R3: Heat/cool stop compressor once target is met, restart when it is not.
// R4: Compressor runs at least 60 seconds once started.
// R5: Compressor stays off at least 3 minutes after stopping.
// R6: Stop period under time save is at most 7 minutes.
// R7: Outdoor fan runs 30 more seconds after each compressor stop.
// R8: Cooling restart delay: indoor fan lowest step 20 s on, 160 s off.
// R9: Soft dry starts once intake temperature reaches target.
// R10: First soft dry ON at most 10 minutes, then OFF at least 6 minutes.
// R11: Later soft dry ON/OFF follows intake versus target.
// R12: Soft dry OFF, compressor off 3 minutes, warm intake: switch to cooling.
// R13: Automatic: lowest fan step 25 seconds, then judge mode from intake.
// R14: Automatic targets: cooling 25, soft dry 22, heating 21 degrees.
// R15: Rejudge after 1 hour if compressor off over 7 min 30 s.
// R16: All timers use one-second tick; run/restart timers beat temperature.
`timescale 1ns/1ps
module aircon_sequencer #(
  parameter int unsigned TICK_CYCLES = aircon_pkg::TICK_CYCLES
) (
  // Clock and reset
  input  wire logic       clock,
  input  wire logic       rst_n,
  // Remote control receiver
  input  wire logic       cmd_valid,
  input  wire logic [2:0] cmd_mode,
  input  wire logic       set_valid,
  input  wire logic [7:0] set_temp,
  // Intake air sensor
  input  wire logic [7:0] intake_temp,
  // Loads
  output logic            compressor,
  output logic            outdoor_fan,
  output logic [1:0]      indoor_fan,
  // Status
  output logic [4:0]      op_mode,
  output logic [7:0]      target_temp
);

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  typedef struct packed {
    aircon_pkg::op_t  op;
    aircon_pkg::dry_t dry_ph;
    logic             auto_on;
    logic [7:0]       target;
    logic             comp;
    logic             ran;
    logic             odfan;
    logic [1:0]       ifan;
    logic [11:0]      run_cnt;
    logic [11:0]      off_cnt;
    logic [11:0]      ph_cnt;
    logic [11:0]      auto_cnt;
  } seq_state_t;

  seq_state_t s;
  seq_state_t next_s;
  logic       tick;
  logic       want;
  logic       time_save;

  // R16 single tick
  sec_tick #(
    .TICK_CYCLES (TICK_CYCLES)
  ) u_tick (
    .clock (clock),
    .rst_n (rst_n),
    .tick  (tick)
  );

  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------
  always_comb begin
    next_s = s;
    want = 1'b0;
    time_save = 1'b0;
    if (tick) begin
      if (s.run_cnt != aircon_pkg::COUNT_MAX) next_s.run_cnt = s.run_cnt + 12'h1;
      if (s.off_cnt != aircon_pkg::COUNT_MAX) next_s.off_cnt = s.off_cnt + 12'h1;
      if (s.ph_cnt != aircon_pkg::COUNT_MAX) next_s.ph_cnt = s.ph_cnt + 12'h1;
      if (s.auto_cnt != aircon_pkg::COUNT_MAX) next_s.auto_cnt = s.auto_cnt + 12'h1;
    end
    // R2 range check
    if (set_valid && !s.auto_on && set_temp >= aircon_pkg::TEMP_MIN &&
        set_temp <= aircon_pkg::TEMP_MAX) begin
      next_s.target = set_temp;
    end
    // R3 R9 R10 R11 R12 R13 R14 mode behaviour
    case (s.op)
      aircon_pkg::OP_HEAT: begin
        want = intake_temp < s.target;
        time_save = 1'b1;
      end
      aircon_pkg::OP_COOL: begin
        want = intake_temp > s.target;
        time_save = 1'b1;
      end
      aircon_pkg::OP_DRY: begin
        case (s.dry_ph)
          aircon_pkg::DRY_WAIT: begin
            if (intake_temp >= s.target) begin
              next_s.dry_ph = aircon_pkg::DRY_ON;
              next_s.ph_cnt = 12'h0;
            end
          end
          aircon_pkg::DRY_ON: begin
            want = 1'b1;
            if (s.ph_cnt >= aircon_pkg::DRY_ON_MAX_S || intake_temp < s.target) begin
              next_s.dry_ph = aircon_pkg::DRY_OFF;
              next_s.ph_cnt = 12'h0;
            end
          end
          aircon_pkg::DRY_OFF: begin
            if (s.ph_cnt >= aircon_pkg::DRY_OFF_MIN_S) begin
              next_s.dry_ph = aircon_pkg::DRY_CYC;
            end else if (!s.comp && s.off_cnt >= aircon_pkg::DRY_SWITCH_S &&
                         intake_temp > 8'(s.target + aircon_pkg::COOL_ON_OFFSET)) begin
              next_s.op = aircon_pkg::OP_COOL;
            end
          end
          aircon_pkg::DRY_CYC: want = intake_temp > s.target;
          default: next_s.dry_ph = aircon_pkg::DRY_WAIT;
        endcase
      end
      aircon_pkg::OP_JUDGE: begin
        if (s.ph_cnt >= aircon_pkg::AUTO_FAN_S) begin
          next_s.auto_cnt = 12'h0;
          if (intake_temp >= aircon_pkg::JUDGE_COOL) begin
            next_s.op = aircon_pkg::OP_COOL;
            next_s.target = aircon_pkg::STD_COOL;
          end else if (intake_temp >= aircon_pkg::JUDGE_DRY) begin
            next_s.op = aircon_pkg::OP_DRY;
            next_s.dry_ph = aircon_pkg::DRY_WAIT;
            next_s.target = aircon_pkg::STD_DRY;
          end else begin
            next_s.op = aircon_pkg::OP_HEAT;
            next_s.target = aircon_pkg::STD_HEAT;
          end
        end
      end
      aircon_pkg::OP_OFF: want = 1'b0;
      default: next_s.op = aircon_pkg::OP_OFF;
    endcase
    // R15 rejudge
    if (s.auto_on && s.op != aircon_pkg::OP_JUDGE && s.op != aircon_pkg::OP_OFF &&
        s.auto_cnt >= aircon_pkg::REJUDGE_S && !s.comp && s.ran &&
        s.off_cnt > aircon_pkg::REJUDGE_OFF_S) begin
      next_s.op = aircon_pkg::OP_JUDGE;
      next_s.ph_cnt = 12'h0;
    end
    // R1 remote mode command
    if (cmd_valid) begin
      next_s.ph_cnt = 12'h0;
      next_s.dry_ph = aircon_pkg::DRY_WAIT;
      next_s.auto_on = 1'b0;
      case (cmd_mode)
        aircon_pkg::CMD_HEAT: next_s.op = aircon_pkg::OP_HEAT;
        aircon_pkg::CMD_COOL: next_s.op = aircon_pkg::OP_COOL;
        aircon_pkg::CMD_DRY:  next_s.op = aircon_pkg::OP_DRY;
        aircon_pkg::CMD_AUTO: begin
          next_s.op = aircon_pkg::OP_JUDGE;
          next_s.auto_on = 1'b1;
        end
        default: next_s.op = aircon_pkg::OP_OFF;
      endcase
    end
    // R4 R5 R6 R16 compressor gating
    if (s.comp) begin
      if ((!want || s.op == aircon_pkg::OP_OFF) && s.run_cnt >= aircon_pkg::MIN_RUN_S) begin
        next_s.comp = 1'b0;
        next_s.off_cnt = 12'h0;
      end
    end else if (!s.ran || s.off_cnt >= aircon_pkg::RESTART_S) begin
      if (want || (time_save && s.ran && s.off_cnt >= aircon_pkg::TIME_SAVE_S)) begin
        next_s.comp = 1'b1;
        next_s.ran = 1'b1;
        next_s.run_cnt = 12'h0;
      end
    end
    // R7 outdoor fan overrun
    next_s.odfan = next_s.comp || (next_s.ran && next_s.off_cnt < aircon_pkg::ODFAN_S);
    // R8 R13 indoor fan
    if (next_s.op == aircon_pkg::OP_OFF) begin
      next_s.ifan = aircon_pkg::FAN_STOP;
    end else if (next_s.op == aircon_pkg::OP_JUDGE) begin
      next_s.ifan = aircon_pkg::lowest_fan_step;
    end else if (next_s.op == aircon_pkg::OP_COOL && !next_s.comp && next_s.ran &&
                 next_s.off_cnt < 12'(aircon_pkg::IFAN_ON_S + aircon_pkg::IFAN_OFF_S)) begin
      next_s.ifan = (next_s.off_cnt < aircon_pkg::IFAN_ON_S) ?
                    aircon_pkg::lowest_fan_step : aircon_pkg::FAN_STOP;
    end else begin
      next_s.ifan = aircon_pkg::FAN_USER;
    end
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      s <= '{op: aircon_pkg::OP_OFF, dry_ph: aircon_pkg::DRY_WAIT,
             target: aircon_pkg::RESET_TARGET, default: '0};
    end else begin
      s <= next_s;
    end
  end

  assign compressor  = s.comp;
  assign outdoor_fan = s.odfan;
  assign indoor_fan  = s.ifan;
  assign op_mode     = s.op;
  assign target_temp = s.target;

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  AST_MODE_HEAT: assert property (@(posedge clock) disable iff (!rst_n) // R1
    cmd_valid && cmd_mode == aircon_pkg::CMD_HEAT |=> s.op == aircon_pkg::OP_HEAT)
    else $error("heat command not taken");
  AST_TARGET_RANGE: assert property (@(posedge clock) disable iff (!rst_n) // R2
    s.target >= aircon_pkg::TEMP_MIN && s.target <= aircon_pkg::TEMP_MAX)
    else $error("target out of range");
  AST_MIN_RUN: assert property (@(posedge clock) disable iff (!rst_n) // R4
    s.comp && s.run_cnt < aircon_pkg::MIN_RUN_S |=> s.comp)
    else $error("compressor stopped before minimum run");
  AST_RESTART: assert property (@(posedge clock) disable iff (!rst_n) // R5
    !s.comp && s.ran && s.off_cnt < aircon_pkg::RESTART_S |=> !s.comp)
    else $error("compressor restarted inside delay");
  AST_TIME_SAVE: assert property (@(posedge clock) disable iff (!rst_n) // R6
    s.op == aircon_pkg::OP_HEAT && !cmd_valid && !s.comp && s.ran &&
    s.off_cnt >= aircon_pkg::TIME_SAVE_S |=> s.comp)
    else $error("stop period exceeded time save");
  AST_ODFAN: assert property (@(posedge clock) disable iff (!rst_n) // R7
    $fell(s.comp) |-> s.odfan ##1 s.odfan)
    else $error("outdoor fan stopped with compressor");
  AST_IFAN_OFF: assert property (@(posedge clock) disable iff (!rst_n) // R8
    s.op == aircon_pkg::OP_COOL && !s.comp && s.ran && s.off_cnt >= aircon_pkg::IFAN_ON_S &&
    s.off_cnt < aircon_pkg::RESTART_S |-> s.ifan == aircon_pkg::FAN_STOP)
    else $error("indoor fan on during off slot");
  AST_DRY_ON_MAX: assert property (@(posedge clock) disable iff (!rst_n) // R10
    s.op == aircon_pkg::OP_DRY && s.dry_ph == aircon_pkg::DRY_ON |->
    s.ph_cnt <= aircon_pkg::DRY_ON_MAX_S)
    else $error("soft dry on phase too long");
  AST_JUDGE_FAN: assert property (@(posedge clock) disable iff (!rst_n) // R13
    s.op == aircon_pkg::OP_JUDGE |-> s.ifan == aircon_pkg::lowest_fan_step)
    else $error("judge fan not at lowest step");

endmodule

// >>> inc/aircon_pkg.sv
// Shared constants and types of the air-conditioner mode and compressor sequencer
package aircon_pkg;

  // ----------------------------------------------------------------
  // Clock and tick
  // ----------------------------------------------------------------
  localparam int unsigned CLOCK_NS     = 40;
  localparam int unsigned TICK_NS      = 1_000_000_000;
  localparam int unsigned TICK_CYCLES  = TICK_NS / CLOCK_NS;

  // ----------------------------------------------------------------
  // Intervals in seconds
  // ----------------------------------------------------------------
  localparam logic [11:0] MIN_RUN_S     = 12'd60;
  localparam logic [11:0] RESTART_S     = 12'd180;
  localparam logic [11:0] TIME_SAVE_S   = 12'd420;
  localparam logic [11:0] ODFAN_S       = 12'd30;
  localparam logic [11:0] IFAN_ON_S     = 12'd20;
  localparam logic [11:0] IFAN_OFF_S    = 12'd160;
  localparam logic [11:0] DRY_ON_MAX_S  = 12'd600;
  localparam logic [11:0] DRY_OFF_MIN_S = 12'd360;
  localparam logic [11:0] DRY_SWITCH_S  = 12'd180;
  localparam logic [11:0] AUTO_FAN_S    = 12'd25;
  localparam logic [11:0] REJUDGE_S     = 12'd3600;
  localparam logic [11:0] REJUDGE_OFF_S = 12'd450;
  localparam logic [11:0] COUNT_MAX     = 12'hFFF;

  // ----------------------------------------------------------------
  // Temperatures in whole degrees Celsius
  // ----------------------------------------------------------------
  localparam logic [7:0] TEMP_MIN       = 8'd16;
  localparam logic [7:0] TEMP_MAX       = 8'd30;
  localparam logic [7:0] STD_COOL       = 8'd25;
  localparam logic [7:0] STD_DRY        = 8'd22;
  localparam logic [7:0] STD_HEAT       = 8'd21;
  localparam logic [7:0] JUDGE_COOL     = 8'd23;
  localparam logic [7:0] JUDGE_DRY      = 8'd20;
  localparam logic [7:0] COOL_ON_OFFSET = 8'd1;
  localparam logic [7:0] RESET_TARGET   = 8'd25;

  // ----------------------------------------------------------------
  // Remote commands and fan steps
  // ----------------------------------------------------------------
  localparam logic [2:0] CMD_OFF  = 3'h0;
  localparam logic [2:0] CMD_HEAT = 3'h1;
  localparam logic [2:0] CMD_COOL = 3'h2;
  localparam logic [2:0] CMD_DRY  = 3'h3;
  localparam logic [2:0] CMD_AUTO = 3'h4;

  localparam logic [1:0] FAN_STOP        = 2'h0;
  localparam logic [1:0] lowest_fan_step = 2'h1;
  localparam logic [1:0] FAN_USER        = 2'h2;

  typedef enum logic [4:0] {
    OP_OFF   = 5'h01,
    OP_HEAT  = 5'h02,
    OP_COOL  = 5'h04,
    OP_DRY   = 5'h08,
    OP_JUDGE = 5'h10
  } op_t;

  typedef enum logic [3:0] {
    DRY_WAIT = 4'h1,
    DRY_ON   = 4'h2,
    DRY_OFF  = 4'h4,
    DRY_CYC  = 4'h8
  } dry_t;

endpackage

// >>> core/sec_tick.sv
// One-cycle pulse every TICK_CYCLES clocks
`timescale 1ns/1ps
module sec_tick #(
  parameter int unsigned TICK_CYCLES = aircon_pkg::TICK_CYCLES
) (
  // Clock and reset
  input  wire logic clock,
  input  wire logic rst_n,
  // Tick out
  output logic      tick
);

  typedef struct packed {
    logic [31:0] cnt;
    logic        tick;
  } tick_state_t;

  tick_state_t s;
  tick_state_t next_s;

  always_comb begin
    next_s = s;
    next_s.tick = 1'b0;
    if (s.cnt >= 32'(TICK_CYCLES - 1)) begin
      next_s.cnt = 32'h0;
      next_s.tick = 1'b1;
    end else begin
      next_s.cnt = s.cnt + 32'h1;
    end
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      s <= '0;
    end else begin
      s <= next_s;
    end
  end

  assign tick = s.tick;

endmodule

// >>> testbench/remote_model.sv
// Remote receiver and intake sensor model driving the sequencer inputs
`timescale 1ns/1ps
module remote_model (
  // Clock
  input  wire logic       clock,
  // Remote commands
  output logic            cmd_valid,
  output logic [2:0]      cmd_mode,
  output logic            set_valid,
  output logic [7:0]      set_temp,
  // Sensor
  output logic [7:0]      intake_temp
);
  initial begin
    cmd_valid   = 1'b0;
    cmd_mode    = 3'h0;
    set_valid   = 1'b0;
    set_temp    = 8'h19;
    intake_temp = 8'h19;
  end

  // Released lines carry the inverse; an inverted cmd_mode can still be a valid command, e.g. CMD_AUTO becomes CMD_DRY
  task automatic send_cmd(input logic [2:0] m);
    @(posedge clock);
    cmd_valid <= 1'b1;
    cmd_mode  <= m;
    @(posedge clock);
    cmd_valid <= 1'b0;
    cmd_mode  <= ~m;
  endtask

  task automatic send_set(input logic [7:0] t);
    @(posedge clock);
    set_valid <= 1'b1;
    set_temp  <= t;
    @(posedge clock);
    set_valid <= 1'b0;
    set_temp  <= ~t;
  endtask

  task automatic set_intake(input logic [7:0] t);
    @(posedge clock);
    intake_temp <= t;
  endtask
endmodule

// >>> testbench/tb.sv
// Self-checking bench of the mode and compressor sequencer
`timescale 1ns/1ps
`define CHK(nm, ex, gt) begin tests_run++; if ((gt) !== (ex)) begin error_cnt++; \
  $display("[ERR] %s exp %0h got %0h", nm, ex, gt); end end
module tb;
  localparam int TK = 4;
  logic       clock = 1'b0;
  logic       rst_n = 1'b0;
  logic       cmd_valid;
  logic [2:0] cmd_mode;
  logic       set_valid;
  logic [7:0] set_temp;
  logic [7:0] intake_temp;
  logic       compressor;
  logic       outdoor_fan;
  logic [1:0] indoor_fan;
  logic [4:0] op_mode;
  logic [7:0] target_temp;
  int         error_cnt = 0;
  int         tests_run = 0;
  logic [7:0] exp_t;
  logic [7:0] v;
  logic [2:0] m;

  always #20 clock = ~clock;

  remote_model u_room (
    .clock(clock), .cmd_valid(cmd_valid), .cmd_mode(cmd_mode),
    .set_valid(set_valid), .set_temp(set_temp), .intake_temp(intake_temp));

  aircon_sequencer #(.TICK_CYCLES(TK)) uut (
    .clock(clock), .rst_n(rst_n), .cmd_valid(cmd_valid), .cmd_mode(cmd_mode),
    .set_valid(set_valid), .set_temp(set_temp), .intake_temp(intake_temp),
    .compressor(compressor), .outdoor_fan(outdoor_fan), .indoor_fan(indoor_fan),
    .op_mode(op_mode), .target_temp(target_temp));

  // ----------------------------------------------------------------
  // Expectations
  // ----------------------------------------------------------------
  function automatic logic [7:0] accept(input logic [7:0] p, input logic [7:0] t);
    return (t >= 8'h10 && t <= 8'h1E) ? t : p;
  endfunction

  function automatic logic [4:0] op_of(input logic [2:0] c);
    case (c)
      3'h1: return 5'h02;
      3'h2: return 5'h04;
      3'h3: return 5'h08;
      3'h4: return 5'h10;
      default: return 5'h01;
    endcase
  endfunction

  function automatic logic [12:0] judge(input logic [7:0] t);
    if (t >= 8'h17) return {5'h04, 8'h19};
    if (t >= 8'h14) return {5'h08, 8'h16};
    return {5'h02, 8'h15};
  endfunction

  task automatic ticks(input int n);
    repeat (n * TK) @(posedge clock);
    #1;
  endtask

  task automatic settle();
    repeat (2) @(posedge clock);
    #1;
  endtask

  task automatic summarize();
    $display("checks %0d errors %0d", tests_run, error_cnt);
    if (error_cnt == 0 && tests_run > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask

  initial begin
    repeat (20000) @(posedge clock);
    error_cnt++;
    summarize();
  end

  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial begin
    void'($urandom(32'h0277e81c));
    repeat (5) @(posedge clock);
    rst_n <= 1'b1;
    settle();
    `CHK("comp_rst", 1'b0, compressor)
    `CHK("op_rst", 5'h01, op_mode)
    `CHK("tgt_rst", 8'h19, target_temp)
    exp_t = 8'h19;
    for (int i = 0; i < 8; i++) begin
      v = (i == 0) ? 8'h0F : (i == 1) ? 8'h10 : (i == 2) ? 8'h1F : (i == 3) ? 8'h1E :
          8'(8'h0C + $urandom % 22);
      u_room.send_set(v);
      exp_t = accept(exp_t, v);
      settle();
      `CHK("target", exp_t, target_temp) // range limit
    end
    u_room.send_set(8'h19);
    u_room.set_intake(8'h1E);
    u_room.send_cmd(3'h2);
    settle();
    `CHK("comp_on", 1'b1, compressor) // started
    `CHK("odfan_on", 1'b1, outdoor_fan) // running
    u_room.set_intake(8'h10);
    ticks(55);
    `CHK("min_run", 1'b1, compressor) // minimum run
    ticks(10);
    `CHK("comp_off", 1'b0, compressor) // stopped
    ticks(6);
    `CHK("ifan_on", 2'h1, indoor_fan) // lowest step
    ticks(15);
    `CHK("odfan_run", 1'b1, outdoor_fan) // after stop
    ticks(10);
    `CHK("odfan_end", 1'b0, outdoor_fan) // ended
    `CHK("ifan_off", 2'h0, indoor_fan) // off phase
    u_room.set_intake(8'h1E);
    ticks(130);
    `CHK("delay", 1'b0, compressor) // restart delay
    ticks(30);
    `CHK("restart", 1'b1, compressor) // restarted
    u_room.send_cmd(3'h1);
    for (int i = 0; i < 100 * TK && compressor === 1'b1; i++) begin
      @(posedge clock);
      #1;
    end
    `CHK("heat_stop", 1'b0, compressor) // heat satisfied
    ticks(410);
    `CHK("save_wait", 1'b0, compressor) // still off
    ticks(15);
    `CHK("save_on", 1'b1, compressor) // forced restart
    for (int i = 0; i < 6; i++) begin
      m = (i == 5) ? 3'h7 : 3'(i == 4 ? 0 : i + 1);
      u_room.send_cmd(m);
      settle();
      `CHK("op_mode", op_of(m), op_mode) // mode select
    end
    for (int i = 0; i < 3; i++) begin
      v = (i == 0) ? 8'(8'h17 + $urandom % 8) : (i == 1) ? 8'(8'h14 + $urandom % 3) :
          8'(8'h10 + $urandom % 4);
      u_room.set_intake(v);
      u_room.send_cmd(3'h4);
      settle();
      `CHK("auto_op", 5'h10, op_mode) // judging
      `CHK("auto_fan", 2'h1, indoor_fan) // lowest step
      ticks(20);
      `CHK("auto_wait", 5'h10, op_mode) // full interval
      ticks(10);
      `CHK("auto_mode", judge(v), {op_mode, target_temp}) // standard target
      u_room.send_set(8'h1E);
      settle();
      `CHK("auto_set", judge(v), {op_mode, target_temp}) // set ignored
    end
    // Second reset in mid-run, then soft dry from a clean state
    @(posedge clock);
    rst_n <= 1'b0;
    repeat (5) @(posedge clock);
    rst_n <= 1'b1;
    settle();
    `CHK("comp_rst2", 1'b0, compressor)
    `CHK("odfan_rst2", 1'b0, outdoor_fan)
    `CHK("ifan_rst2", 2'h0, indoor_fan)
    `CHK("op_rst2", 5'h01, op_mode)
    `CHK("tgt_rst2", 8'h19, target_temp)
    u_room.set_intake(8'h1A);
    u_room.send_cmd(3'h3);
    settle();
    `CHK("dry_start", 1'b1, compressor)
    `CHK("dry_ifan", 2'h2, indoor_fan)
    ticks(590);
    `CHK("dry_on", 1'b1, compressor)
    ticks(15);
    `CHK("dry_on_end", 1'b0, compressor)
    ticks(340);
    `CHK("dry_off_min", 1'b0, compressor)
    `CHK("dry_stay", 5'h08, op_mode)
    ticks(25);
    `CHK("dry_cyc_on", 1'b1, compressor)
    u_room.set_intake(8'h18);
    ticks(65);
    `CHK("dry_cyc_off", 1'b0, compressor)
    // Short ON phase with compressor held off, then warm intake in OFF phase
    u_room.send_cmd(3'h3);
    u_room.set_intake(8'h1A);
    settle();
    u_room.set_intake(8'h18);
    ticks(60);
    u_room.set_intake(8'h1B);
    ticks(5);
    `CHK("dry_early", 5'h08, op_mode)
    ticks(110);
    `CHK("dry_to_cool", 5'h04, op_mode)
    `CHK("cool_after_dry", 1'b1, compressor)
    summarize();
  end
endmodule
